//--- design/datapath_pkg.sv
/*
  shared constants and types of the twelve-bit register datapath.
  assumes bit 00 is the most significant bit; vectors are declared [0:11].
*/
package datapath_pkg;

  // ------------------------------------------------------------
  // widths and slicing
  // ------------------------------------------------------------
  localparam int WORD_W          = 12;
  localparam int SLICE_W         = 2;
  localparam int SLICES          = 6;
  localparam int LAB_CARRY_SLICE = 0;

  // ------------------------------------------------------------
  // reset values and enable masks
  // ------------------------------------------------------------
  localparam logic [0:11] REG_RST        = 12'h000;
  localparam logic [0:11] FULL_MASK      = 12'hfff;
  localparam logic [0:11] PTR_LAB_MASK   = 12'h3ff;
  localparam logic [0:11] ACC_LEFT_MASK  = 12'hfc0;
  localparam logic [0:11] ACC_RIGHT_MASK = 12'h03f;
  localparam logic [0:11] IR_MID_MASK    = 12'h3f0;
  localparam logic [0:11] IR_LOW_MASK    = 12'h00f;

  // ------------------------------------------------------------
  // field positions and skip pools
  // ------------------------------------------------------------
  localparam int IR_SENSE_BIT  = 7;
  localparam int MB_HALF_BIT   = 0;
  localparam int INT_SKIPS     = 14;
  localparam int EXT_SKIPS     = 12;
  localparam int EXT_INT_SKIPS = 4;
  localparam int SKIP_SEL_W    = 4;
  localparam int PIN_W         = 48;

  typedef enum logic [1:0] {
    SKIP_INT = 2'b00,
    SKIP_EXT = 2'b01,
    SKIP_CMP = 2'b11
  } skip_src_e;

  typedef enum logic [1:0] {
    SH_NONE  = 2'b00,
    SH_RIGHT = 2'b01,
    SH_LEFT  = 2'b11
  } shift_e;

endpackage

//--- design/register_bit_slice.sv
/*
  two-bit slice: accumulator, memory buffer, pointer and address bits,
  two gated adder operands and the local ripple carry.
  assumes the bus and all enables come from logic on the same clock.
*/
`timescale 1ns/10ps
module register_bit_slice (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       carry_in,
  input  wire logic [0:1] acc_en,
  input  wire logic       comp_en,
  input  wire logic [0:1] sw,
  input  wire logic       sw_en,
  input  wire logic [0:1] brk,
  input  wire logic       brk_en,
  input  wire logic [0:1] mem,
  input  wire logic       mem_en,
  input  wire logic       mb_en,
  input  wire logic [0:1] ptr_en,
  input  wire logic       ma_en,
  input  wire logic [0:1] irf,
  input  wire logic [0:1] irf_en,
  input  wire logic [0:1] bus,
  input  wire logic       load_acc,
  input  wire logic       load_mb,
  input  wire logic       load_ptr,
  input  wire logic       load_ma,
  output logic      [0:1] acc_q,
  output logic      [0:1] mb_q,
  output logic      [0:1] ptr_q,
  output logic      [0:1] ma_q,
  output logic      [0:1] sum,
  output logic            carry_out,
  output logic            equal
);
  import datapath_pkg::*;

  logic [0:1] op_a;
  logic [0:1] op_b;
  logic [0:2] cy;

  // and/or enable gates, one per source
  assign op_a = (acc_q & acc_en) | (~acc_q & {2{comp_en}}) | (sw & {2{sw_en}})
              | (brk & {2{brk_en}}) | (mem & {2{mem_en}});
  assign op_b = (mb_q & {2{mb_en}}) | (ptr_q & ptr_en) | (ma_q & {2{ma_en}})
              | (irf & irf_en);

  assign cy[2] = carry_in;
  genvar i;
  generate
    for (i = 0; i < SLICE_W; i++) begin : g_bit
      assign sum[i] = op_a[i] ^ op_b[i] ^ cy[i+1];
      assign cy[i]  = (op_a[i] & op_b[i]) | (cy[i+1] & (op_a[i] ^ op_b[i]));
    end
  endgenerate
  assign carry_out = cy[0];
  assign equal     = (acc_q == mb_q);

  always_ff @(posedge clk) begin
    if (rst) acc_q <= REG_RST[0:1];
    else if (ce && load_acc) acc_q <= bus;
  end
  always_ff @(posedge clk) begin
    if (rst) mb_q <= REG_RST[0:1];
    else if (ce && load_mb) mb_q <= bus;
  end
  always_ff @(posedge clk) begin
    if (rst) ptr_q <= REG_RST[0:1];
    else if (ce && load_ptr) ptr_q <= bus;
  end
  always_ff @(posedge clk) begin
    if (rst) ma_q <= REG_RST[0:1];
    else if (ce && load_ma) ma_q <= bus;
  end
endmodule

//--- design/processor_register_datapath.sv
/*
  twelve-bit processor register datapath: six bit slices, operand enables,
  shift network, load strobes, multiplier/quotient, skip and half-word flags.
  assumes time pulses, states and opcodes come from logic on clk;
  switches, break address, memory sense and external levels are pins.
*/
`timescale 1ns/10ps
module processor_register_datapath (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   lab_mode,
  input  wire logic                   first_time_pulse,
  input  wire logic                   third_time_pulse,
  input  wire logic                   fifth_time_state,
  input  wire logic                   manual_second_pulse,
  input  wire logic                   indirect_cycle,
  input  wire logic                   second_exec_state,
  input  wire logic                   exec_state,
  input  wire logic                   fetch_state,
  input  wire logic                   set_op,
  input  wire logic                   product_op,
  input  wire logic                   zero_op,
  input  wire logic                   display_char_op,
  input  wire logic                   extended_arith_op,
  input  wire logic                   rotate_op,
  input  wire logic                   octal_cma_op,
  input  wire logic                   cma_strobe,
  input  wire logic                   half_op,
  input  wire logic                   index_op,
  input  wire logic                   acc_en,
  input  wire logic                   acc_comp_req,
  input  wire logic                   console_switch_enable,
  input  wire logic                   break_address_enable,
  input  wire logic                   mem_en,
  input  wire logic                   mb_en,
  input  wire logic                   ptr_en,
  input  wire logic                   ma_en,
  input  wire logic                   ir_field_en,
  input  wire logic                   ir_field_low,
  input  wire logic                   no_shift,
  input  wire logic                   shift_right,
  input  wire logic                   shift_left,
  input  wire logic                   high_end_in,
  input  wire logic                   low_end_in,
  input  wire logic                   incr_req,
  input  wire logic                   load_acc,
  input  wire logic                   load_ptr,
  input  wire logic                   load_ir,
  input  wire logic                   load_mq_req,
  input  wire logic                   mq_shift_right,
  input  wire logic                   mq_shift_left,
  input  wire logic                   skip_exec,
  input  wire logic                   lab_skip,
  input  wire datapath_pkg::skip_src_e skip_src,
  input  wire logic [3:0]             skip_sel,
  input  wire logic [0:13]            int_conds,
  input  wire logic [0:11]            ext_levels,
  input  wire logic                   flag_clear_signal_n,
  input  wire logic [0:11]            console_switches,
  input  wire logic [0:11]            break_address,
  input  wire logic [0:11]            mem_sense,
  output logic      [0:11]            accumulator,
  output logic      [0:11]            memory_buffer,
  output logic      [0:11]            memory_address_reg,
  output logic      [0:11]            instruction_pointer,
  output logic      [0:11]            multiplier_quotient,
  output logic      [0:11]            instruction_latch,
  output logic                        skip_flag,
  output logic                        half_flag,
  output logic                        fetch_skip,
  output logic                        carry_out,
  output logic                        acc_mb_equal
);
  import datapath_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [0:11]      sw_s;
  logic [0:11]      brk_s;
  logic [0:11]      mem_s;
  logic [0:11]      ext_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce) begin
      pin_meta_q <= {console_switches, break_address, mem_sense, ext_levels};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign {sw_s, brk_s, mem_s, ext_s} = pin_sync_q;

  // ------------------------------------------------------------
  // operand enables
  // ------------------------------------------------------------
  logic [0:11] acc_mask;
  logic [0:11] ptr_mask;
  logic [0:11] ir_mask;
  logic        comp_go;

  always_comb begin
    acc_mask = '0;
    if (acc_en)
      acc_mask = half_op ? (half_flag ? ACC_RIGHT_MASK : ACC_LEFT_MASK) : FULL_MASK;
  end
  // octal complement rides its own strobe, all others use the fifth state
  assign comp_go  = octal_cma_op ? cma_strobe : (acc_comp_req & fifth_time_state);
  assign ptr_mask = ptr_en ? (lab_mode ? PTR_LAB_MASK : FULL_MASK) : '0;
  assign ir_mask  = ir_field_en ? (ir_field_low ? IR_LOW_MASK : IR_MID_MASK) : '0;

  // ------------------------------------------------------------
  // carry chain and slices
  // ------------------------------------------------------------
  logic [0:SLICES] cy;
  logic [0:11]     sum;
  logic [0:11]     bus;
  logic [0:SLICES-1] eq_part;
  logic            carry_ins;
  logic            lab_stop;
  logic            load_mb;
  logic            load_ma;

  assign carry_ins  = incr_req | (skip_flag & fetch_state);
  assign cy[SLICES] = carry_ins;
  // blocks the indexing carry into bits 00-01, which hold the field
  assign lab_stop   = lab_mode & index_op;

  genvar k;
  generate
    for (k = 0; k < SLICES; k++) begin : g_slice
      logic cin;
      if (k == LAB_CARRY_SLICE) begin : g_stop
        assign cin = cy[k+1] & ~lab_stop;
      end else begin : g_pass
        assign cin = cy[k+1];
      end
      register_bit_slice u_slice (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .carry_in  (cin),
        .acc_en    (acc_mask[2*k +: 2]),
        .comp_en   (comp_go),
        .sw        (sw_s[2*k +: 2]),
        .sw_en     (console_switch_enable),
        .brk       (brk_s[2*k +: 2]),
        .brk_en    (break_address_enable),
        .mem       (mem_s[2*k +: 2]),
        .mem_en    (mem_en),
        .mb_en     (mb_en),
        .ptr_en    (ptr_mask[2*k +: 2]),
        .ma_en     (ma_en),
        .irf       (instruction_latch[2*k +: 2]),
        .irf_en    (ir_mask[2*k +: 2]),
        .bus       (bus[2*k +: 2]),
        .load_acc  (load_acc),
        .load_mb   (load_mb),
        .load_ptr  (load_ptr),
        .load_ma   (load_ma),
        .acc_q     (accumulator[2*k +: 2]),
        .mb_q      (memory_buffer[2*k +: 2]),
        .ptr_q     (instruction_pointer[2*k +: 2]),
        .ma_q      (memory_address_reg[2*k +: 2]),
        .sum       (sum[2*k +: 2]),
        .carry_out (cy[k]),
        .equal     (eq_part[k])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // shift network
  // ------------------------------------------------------------
  shift_e sh;

  // priority keeps the three controls mutually exclusive even if misdriven
  always_comb begin
    if (no_shift)         sh = SH_NONE;
    else if (shift_right) sh = SH_RIGHT;
    else if (shift_left)  sh = SH_LEFT;
    else                  sh = SH_NONE;
  end

  always_comb begin
    case (sh)
      SH_NONE:  bus = sum;
      SH_RIGHT: bus = {high_end_in, sum[0:10]};
      SH_LEFT:  bus = {sum[1:11], low_end_in};
      default:  bus = sum;
    endcase
  end

  // ------------------------------------------------------------
  // load strobes
  // ------------------------------------------------------------
  logic mq_ops;
  logic mq_load;

  assign load_mb = third_time_pulse & ~(set_op & second_exec_state);
  assign load_ma = manual_second_pulse | first_time_pulse;
  assign mq_ops  = product_op | zero_op | (display_char_op & exec_state)
                 | extended_arith_op | rotate_op;
  assign mq_load = load_mq_req & mq_ops;

  always_ff @(posedge clk) begin
    if (rst) instruction_latch <= REG_RST;
    else if (ce && load_ir) instruction_latch <= bus;
  end

  always_ff @(posedge clk) begin
    if (rst) multiplier_quotient <= REG_RST;
    else if (ce) begin
      if (mq_load) multiplier_quotient <= bus;
      // multiply feeds the low accumulator bit into the top of the quotient
      else if (mq_shift_right)
        multiplier_quotient <= {(product_op ? accumulator[11] : multiplier_quotient[11]),
                                multiplier_quotient[0:10]};
      else if (mq_shift_left)
        multiplier_quotient <= {multiplier_quotient[1:11], multiplier_quotient[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) carry_out <= 1'b0;
    else if (ce) carry_out <= cy[0];
  end

  // ------------------------------------------------------------
  // skip selection and flags
  // ------------------------------------------------------------
  logic [0:15] ext_pool;
  logic        int_sense;
  logic        ext_sense;
  logic        skip_cond;
  logic        cmp_eq;

  assign cmp_eq    = &eq_part;
  assign int_sense = (skip_sel < 4'(INT_SKIPS)) ? int_conds[skip_sel] : 1'b0;
  assign ext_pool  = {ext_s, int_conds[0:EXT_INT_SKIPS-1]};
  assign ext_sense = ext_pool[skip_sel];

  always_comb begin
    case (skip_src)
      SKIP_INT: skip_cond = int_sense;
      SKIP_EXT: skip_cond = ext_sense;
      SKIP_CMP: skip_cond = cmp_eq;
      default:  skip_cond = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) fetch_skip <= 1'b0;
    else if (ce) fetch_skip <= lab_skip & skip_cond & instruction_latch[IR_SENSE_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) acc_mb_equal <= 1'b0;
    else if (ce) acc_mb_equal <= cmp_eq;
  end

  // the common clear is asynchronous and wins over a set in the same cycle
  always_ff @(posedge clk or negedge flag_clear_signal_n) begin
    if (!flag_clear_signal_n) skip_flag <= 1'b0;
    else if (rst) skip_flag <= 1'b0;
    else if (ce && skip_exec && skip_cond) skip_flag <= 1'b1;
  end

  always_ff @(posedge clk or negedge flag_clear_signal_n) begin
    if (!flag_clear_signal_n) half_flag <= 1'b0;
    else if (rst) half_flag <= 1'b0;
    else if (ce && indirect_cycle && memory_buffer[MB_HALF_BIT]) half_flag <= 1'b1;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_shift_right_bus: assert property (@(posedge clk) disable iff (rst)
    shift_right && !no_shift |-> bus == {high_end_in, sum[0:10]})
    else $error("right shift did not win over left");
  a_mb_tp3_load: assert property (@(posedge clk) disable iff (rst)
    ce && third_time_pulse && !(set_op && second_exec_state) |=> memory_buffer == $past(bus))
    else $error("buffer missed its third pulse load");
  a_mb_set_hold: assert property (@(posedge clk) disable iff (rst)
    ce && third_time_pulse && set_op && second_exec_state |=> $stable(memory_buffer))
    else $error("buffer loaded during set in second execute");
  a_ma_load_pulse: assert property (@(posedge clk) disable iff (rst)
    ce && (manual_second_pulse || first_time_pulse) |=> memory_address_reg == $past(bus))
    else $error("address register missed its load");
  a_mq_load_guard: assert property (@(posedge clk) disable iff (rst)
    ce && load_mq_req && !mq_ops && !mq_shift_right && !mq_shift_left |=> $stable(multiplier_quotient))
    else $error("quotient loaded for a foreign instruction");
  a_skip_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && skip_exec && skip_cond |=> skip_flag || !flag_clear_signal_n)
    else $error("true skip did not set the flag");
  a_skip_flag_hold: assert property (@(posedge clk) disable iff (rst)
    !skip_flag ##1 !skip_flag && flag_clear_signal_n |-> !$past(ce) || !$past(skip_exec) || !$past(skip_cond))
    else $error("skip flag stayed clear after a true skip");
  a_half_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && indirect_cycle && memory_buffer[MB_HALF_BIT] |=> half_flag || !flag_clear_signal_n)
    else $error("half flag not set in indirect cycle");
  a_lab_carry_stop: assert property (@(posedge clk) disable iff (rst)
    lab_mode && index_op |-> !g_slice[LAB_CARRY_SLICE].cin)
    else $error("carry passed into field bits in lab mode");
  a_skip_carry_in: assert property (@(posedge clk) disable iff (rst)
    skip_flag && fetch_state |-> cy[SLICES])
    else $error("skip flag gave no carry insert in fetch");
  a_fetch_skip_bit: assert property (@(posedge clk) disable iff (rst)
    fetch_skip && $past(ce) |-> $past(instruction_latch[IR_SENSE_BIT]) && $past(lab_skip) && $past(skip_cond))
    else $error("fetch skip without instruction bit 07");
  a_compare_value: assert property (@(posedge clk) disable iff (rst)
    ce |=> acc_mb_equal == ($past(accumulator) == $past(memory_buffer)))
    else $error("compare flag disagrees with registers");
endmodule

//--- sim/core_memory_model.sv
/*
  core memory model: 64 words, written from the buffer, read onto the sense pins.
  assumes rd and wr are levels from the bench on clk.
*/
`timescale 1ns/10ps
module core_memory_model (
  input  wire logic        clk,
  input  wire logic [0:11] addr,
  input  wire logic [0:11] wdata,
  input  wire logic        rd,
  input  wire logic        wr,
  output logic      [0:11] sense
);
  logic [0:11] cells [64];
  logic [0:11] last_q = 12'h000;

  always_ff @(posedge clk) begin
    if (wr) begin
      cells[addr[6:11]] <= wdata;
    end
    if (rd) begin
      last_q <= cells[addr[6:11]];
    end
  end

  // released lines show the inverse of the last word, never a stale copy
  assign sense = rd ? cells[addr[6:11]] : ~last_q;
endmodule

//--- sim/test_processor_register_datapath.sv
/*
  self-checking bench of the register datapath: transfers, adder, masks,
  flags, quotient loads and shifts.
  assumes core_memory_model answers on the sense pins.
*/
`timescale 1ns/10ps
module test_processor_register_datapath;
  import datapath_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, no_shift = 1'b1, flag_clear_signal_n = 1'b1;
  logic low_end_in = 1'b0, mb_en = 1'b0, ir_field_low = 1'b0;
  logic lab_mode, first_time_pulse, third_time_pulse, fifth_time_state, manual_second_pulse;
  logic indirect_cycle, second_exec_state, exec_state, fetch_state, set_op, product_op, zero_op;
  logic display_char_op, extended_arith_op, rotate_op, octal_cma_op, cma_strobe, half_op, index_op;
  logic acc_en, acc_comp_req, console_switch_enable, break_address_enable, mem_en, ptr_en, ma_en;
  logic ir_field_en, shift_right, shift_left, high_end_in, incr_req, load_acc, load_ptr, load_ir;
  logic load_mq_req, mq_shift_right, mq_shift_left, skip_exec, lab_skip, mem_rd, mem_wr;
  skip_src_e   skip_src = SKIP_INT;
  logic [3:0]  skip_sel = 4'h0;
  logic [0:13] int_conds = 14'h0000;
  logic [0:11] ext_levels = 12'h100, console_switches = 12'h000, break_address = 12'h3c3;
  logic [0:11] mem_sense, accumulator, memory_buffer, memory_address_reg, instruction_pointer;
  logic [0:11] multiplier_quotient, instruction_latch;
  logic        skip_flag, half_flag, fetch_skip, carry_out, acc_mb_equal;
  int          mismatches = 0;
  int          checked = 0;

  processor_register_datapath u_dut (.*);
  core_memory_model u_mem (.clk(clk), .addr(memory_address_reg), .wdata(memory_buffer), .rd(mem_rd),
                           .wr(mem_wr), .sense(mem_sense));

  initial forever #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [0:11] got, input logic [0:11] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clr();
    {lab_mode, first_time_pulse, third_time_pulse, fifth_time_state, manual_second_pulse} <= '0;
    {indirect_cycle, second_exec_state, exec_state, fetch_state, set_op, product_op, zero_op} <= '0;
    {display_char_op, extended_arith_op, rotate_op, octal_cma_op, cma_strobe, half_op} <= '0;
    {index_op, acc_en, acc_comp_req, console_switch_enable, break_address_enable, mem_en} <= '0;
    {ptr_en, ma_en, ir_field_en, shift_right, shift_left, high_end_in, incr_req, load_acc} <= '0;
    {load_ptr, load_ir, load_mq_req, mq_shift_right, mq_shift_left, skip_exec, lab_skip} <= '0;
    {mem_rd, mem_wr, mb_en, low_end_in} <= '0;
    no_shift <= 1'b1;
  endtask

  // strobes stand one cycle; registers are settled 1 ns after that edge
  task automatic done();
    @(posedge clk);
    clr();
    #1;
  endtask

  // pins pass two sync flops, so wait before enabling them
  task automatic put(input logic [0:11] v);
    @(posedge clk);
    console_switches <= v;
    repeat (3) @(posedge clk);
    {console_switch_enable, load_acc} <= '1;
    done();
  endtask

  task automatic clear_flags();
    @(posedge clk);
    flag_clear_signal_n <= 1'b0;
    #1;
    chk(12'({skip_flag, half_flag}), 12'h000);
    @(posedge clk);
    flag_clear_signal_n <= 1'b1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    clr();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(accumulator | memory_buffer | memory_address_reg | instruction_pointer, 12'h000);
    chk(multiplier_quotient | instruction_latch, 12'h000);
    $display("test reset done");
    put(12'ha5c);
    chk(accumulator, 12'ha5c);
    @(posedge clk);
    {acc_en, third_time_pulse, set_op, second_exec_state} <= '1;
    done();
    chk(memory_buffer, 12'h000);
    @(posedge clk);
    {acc_en, third_time_pulse} <= '1;
    done();
    chk(memory_buffer, 12'ha5c);
    @(posedge clk);
    #1;
    chk(12'(acc_mb_equal), 12'h001);
    @(posedge clk);
    skip_src <= SKIP_CMP;
    skip_exec <= 1'b1;
    done();
    chk(12'(skip_flag), 12'h001);
    @(posedge clk);
    {fetch_state, ma_en, first_time_pulse} <= '1;
    done();
    chk(memory_address_reg, 12'h001);
    @(posedge clk);
    {ma_en, incr_req, manual_second_pulse} <= '1;
    done();
    chk(memory_address_reg, 12'h002);
    @(posedge clk);
    mem_wr <= 1'b1;
    done();
    put(12'h000);
    @(posedge clk);
    mem_rd <= 1'b1;
    repeat (3) @(posedge clk);
    {mem_en, load_acc} <= '1;
    done();
    chk(accumulator, 12'ha5c);
    $display("test transfers done");
    @(posedge clk);
    {acc_comp_req, fifth_time_state, load_acc} <= '1;
    done();
    chk(accumulator, 12'h5a3);
    @(posedge clk);
    {octal_cma_op, cma_strobe, load_acc} <= '1;
    done();
    chk(accumulator, 12'ha5c);
    @(posedge clk);
    {acc_comp_req, load_acc} <= '1;
    done();
    chk(accumulator, 12'h000);
    // clock enable low must freeze the load
    @(posedge clk);
    {mb_en, load_acc} <= '1;
    ce <= 1'b0;
    done();
    chk(accumulator, 12'h000);
    @(posedge clk);
    {mb_en, load_acc} <= '1;
    ce <= 1'b1;
    done();
    chk(accumulator, 12'ha5c);
    put(12'hfff);
    @(posedge clk);
    {acc_en, incr_req, load_acc} <= '1;
    done();
    chk(accumulator, 12'h000);
    chk(12'(carry_out), 12'h001);
    put(12'hfff);
    @(posedge clk);
    {lab_mode, index_op, acc_en, incr_req, load_acc} <= '1;
    done();
    chk(accumulator, 12'hc00);
    put(12'ha5c);
    @(posedge clk);
    {acc_en, shift_right, shift_left, high_end_in, load_acc} <= '1;
    no_shift <= 1'b0;
    done();
    chk(accumulator, 12'hd2e);
    @(posedge clk);
    {acc_en, shift_left, low_end_in, load_acc} <= '1;
    no_shift <= 1'b0;
    done();
    chk(accumulator, 12'ha5d);
    @(posedge clk);
    {half_op, acc_en, load_acc} <= '1;
    done();
    chk(accumulator, 12'ha40);
    @(posedge clk);
    indirect_cycle <= 1'b1;
    done();
    chk(12'({skip_flag, half_flag}), 12'h003);
    put(12'ha5c);
    @(posedge clk);
    {half_op, acc_en, load_acc} <= '1;
    done();
    chk(accumulator, 12'h01c);
    clear_flags();
    $display("test adder done");
    put(12'hfff);
    @(posedge clk);
    {console_switch_enable, load_ptr} <= '1;
    done();
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      {ptr_en, load_acc} <= '1;
      lab_mode <= m[0];
      done();
      chk(accumulator, m ? 12'h3ff : 12'hfff);
    end
    // instruction bit 07 still clear: no fetch skip
    @(posedge clk);
    skip_src <= SKIP_INT;
    skip_sel <= 4'd2;
    int_conds <= 14'h0800;
    lab_skip <= 1'b1;
    done();
    chk(12'(fetch_skip), 12'h000);
    put(12'h5b7);
    @(posedge clk);
    {console_switch_enable, load_ir} <= '1;
    done();
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      {ir_field_en, load_acc} <= '1;
      ir_field_low <= f[0];
      done();
      chk(accumulator, f ? 12'h007 : 12'h1b0);
    end
    @(posedge clk);
    skip_src <= SKIP_INT;
    skip_sel <= 4'd2;
    int_conds <= 14'h0800;
    {lab_skip, skip_exec} <= '1;
    done();
    chk(12'({fetch_skip, skip_flag}), 12'h003);
    // pool entries 4, 3 (pins) then 12, 14 (internal conditions 0 and 2)
    for (int s = 0; s < 4; s++) begin
      clear_flags();
      @(posedge clk);
      skip_src <= SKIP_EXT;
      skip_sel <= s[1] ? 4'(12 + 2 * s[0]) : 4'(4 - s[0]);
      skip_exec <= 1'b1;
      done();
      chk(12'(skip_flag), 12'(s[0]));
    end
    $display("test skips done");
    put(12'ha5c);
    @(posedge clk);
    {acc_en, load_mq_req, display_char_op} <= '1;
    done();
    chk(multiplier_quotient, 12'h000);
    for (int i = 0; i < 5; i++) begin
      put(12'(i + 1));
      @(posedge clk);
      {acc_en, load_mq_req, exec_state} <= '1;
      {product_op, zero_op, display_char_op, extended_arith_op, rotate_op} <= 5'(1 << i);
      done();
      chk(multiplier_quotient, 12'(i + 1));
    end
    @(posedge clk);
    {product_op, mq_shift_right} <= '1;
    done();
    chk(multiplier_quotient, 12'h802);
    @(posedge clk);
    mq_shift_left <= 1'b1;
    done();
    chk(multiplier_quotient, 12'h005);
    @(posedge clk);
    {break_address_enable, load_acc} <= '1;
    done();
    chk(accumulator, 12'h3c3);
    $display("test quotient done");
    conclude();
  end
endmodule
